// ==== shared/hsc_defines.vh ====
`ifndef HSC_DEFINES_VH
`define HSC_DEFINES_VH
// ============================================================
// timing
`define HSC_CLK_HZ           200000000
`define HSC_STARTUP_S        20
`define HSC_BLINK_HALF_S     2
`define HSC_HOLD_MIN_S       6
`define HSC_HOLD_MAX_S       9
// ============================================================
// fault codes shown on the display
`define HSC_FAULT_NONE       8'h00
`define HSC_FAULT_MODEL      8'h01
`define HSC_FAULT_BLOWER     8'h02
`define HSC_FAULT_KIT        8'h03
`define HSC_FAULT_STAGE      8'h04
// ============================================================
// switch bank fields
`define HSC_STAGE_LSB        0
`define HSC_KIT_LSB          2
`define HSC_TRIM_LSB         0
`define HSC_MODEL_FACTORY    6'h00
`define HSC_TRIM_PLUS20      2'h1
`define HSC_STAGE_B_ONLY     2'h2
`define HSC_STAGE_BOTH       2'h3
// ============================================================
// display modes
`define HSC_DISP_STARTUP     2'h0
`define HSC_DISP_BLANK       2'h1
`define HSC_DISP_FAULT       2'h2
`define HSC_DISP_MODEL       2'h3
`endif

// ==== rtl/hsc_tick_div.v ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// tick divider: one-cycle pulse every DIV clocks
module hsc_tick_div #(
    parameter DIV = 200000000
) (
    input  wire clock_in,   // system clock
    input  wire rst_n_in,   // async reset, low
    output reg  tick_out    // one-cycle enable
);
    reg [31:0] cnt_q;

    // free-running count; a slow tick keeps the long timers small
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q    <= 32'h0;
            tick_out <= 1'b0;
        end else if (cnt_q == DIV - 1) begin
            cnt_q    <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            cnt_q    <= cnt_q + 32'h1;
            tick_out <= 1'b0;
        end
    end
endmodule // hsc_tick_div
`default_nettype wire

// ==== rtl/hsc_heat_stage_ctrl.v ====
// Contract
// - show startup code, standby after 20 s
// - standby valid model blinks green 2s/2s
// - model mismatch raises fault 01, blower mismatch 02
// - short press shows stored model id
// - all-zero model switches use factory id
// - fault held until 6-9 s button hold
// - switch changes during heat call discarded
// - invalid setting after hold keeps fault
// - kit select from aux switches 3-6
// - trim 01 raises heat airflow 20 percent
// - default: first call A, second B
// - stage 00/01: first call drives A
// - stage 10: first call drives B
// - stage 11: first call drives both
// - single-stage kit with stage 1x: fault 04
// - kit change raises fault 03 until hold
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.vh"
module hsc_heat_stage_ctrl #(
    parameter        CLK_HZ       = `HSC_CLK_HZ,
    parameter        TICK_DIV     = `HSC_CLK_HZ / 10,
    parameter [15:0] STARTUP_T    = `HSC_STARTUP_S * 10,
    parameter [15:0] BLINK_T      = `HSC_BLINK_HALF_S * 10,
    parameter [15:0] HOLD_MIN_T   = `HSC_HOLD_MIN_S * 10,
    parameter [15:0] HOLD_MAX_T   = `HSC_HOLD_MAX_S * 10,
    parameter [7:0]  FACTORY_ID   = 8'h5A,  // arbitrary stored model id
    parameter [15:0] SINGLE_KITS  = 16'h000F, // kits with one stage
    parameter [7:0]  KIT_AIRFLOW  = 8'h40   // airflow of kit 0; each kit adds 16
) (
    input  wire        clock_in,            // 200 MHz clock
    input  wire        rst_n_in,            // async reset, low
    input  wire [5:0]  model_switch_bank_in, // model select switches
    input  wire [5:0]  auxheat_switch_bank_in, // stage[1:0], kit[5:2]
    input  wire [1:0]  airflow_switch_bank_in, // heat airflow trim
    input  wire        first_heat_call_in,  // thermostat first call
    input  wire        second_heat_call_in, // thermostat second call
    input  wire        other_call_in,       // any other stat call
    input  wire        button_in,           // push button, high=pressed
    input  wire        blower_match_in,     // motor program matches
    output reg         heat_relay_a_out,    // heat relay a
    output reg         heat_relay_b_out,    // heat relay b
    output reg         led_green_out,       // status led green
    output reg  [1:0]  disp_mode_out,       // what the display shows
    output reg  [7:0]  disp_code_out,       // code or model id
    output reg         standby_out,         // unit in standby
    output reg  [3:0]  kit_sel_out,         // active heat kit
    output reg  [9:0]  heat_airflow_out     // commanded heat airflow
);
    // ========================================================
    // states
    localparam ST_START   = 2'h0;
    localparam ST_STANDBY = 2'h1;
    localparam ST_FAULT   = 2'h2;

    reg  [1:0]  state_q;
    reg  [15:0] tmr_q;      // startup/blink timer, in ticks
    reg  [15:0] hold_q;     // button hold length, in ticks
    reg         btn_q;
    reg         show_id_q;
    reg         blink_q;
    reg  [5:0]  st_model_q;
    reg  [5:0]  st_aux_q;
    reg  [1:0]  st_trim_q;
    reg  [7:0]  fault_q;
    wire        tick;
    wire        call_any;
    wire [7:0]  cur_fault;
    wire [7:0]  pend_fault;
    wire        hold_ok;
    wire        btn_rel;    // button let go this cycle
    wire [12:0] air_base;   // kit airflow, wide so the trim never wraps
    wire [12:0] air_trim;   // kit airflow raised by a fifth

    hsc_tick_div #(.DIV(TICK_DIV)) u_div (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .tick_out (tick)
    );

    // ========================================================
    // fault evaluation, used for stored and switch settings
    function [7:0] eval_fault;
        input [5:0] model;
        input [5:0] aux;
        input [5:0] st_model;
        input [5:0] st_aux;
        input       blower;
        begin
            if (model != `HSC_MODEL_FACTORY && model != st_model)
                eval_fault = `HSC_FAULT_MODEL;
            else if (aux[5:2] != st_aux[5:2])
                eval_fault = `HSC_FAULT_KIT;
            else if (SINGLE_KITS[aux[5:2]] && aux[1])
                eval_fault = `HSC_FAULT_STAGE;
            else if (aux[1:0] != st_aux[1:0])
                eval_fault = `HSC_FAULT_STAGE;
            else if (!blower)
                eval_fault = `HSC_FAULT_BLOWER;
            else
                eval_fault = `HSC_FAULT_NONE;
        end
    endfunction

    assign call_any = first_heat_call_in | second_heat_call_in
                    | other_call_in;
    // current switches against stored config
    assign cur_fault = eval_fault(model_switch_bank_in,
                                  auxheat_switch_bank_in,
                                  st_model_q, st_aux_q,
                                  blower_match_in);
    // switches as if accepted: only single-stage misuse remains
    assign pend_fault = (SINGLE_KITS[auxheat_switch_bank_in[5:2]]
                         && auxheat_switch_bank_in[1])
                        ? `HSC_FAULT_STAGE : `HSC_FAULT_NONE;
    assign btn_rel = btn_q & ~button_in;
    assign hold_ok = btn_rel && hold_q >= HOLD_MIN_T
                     && hold_q <= HOLD_MAX_T;

    // airflow worked out at 13 bits: the product by six overflows 10
    assign air_base = {5'h00, KIT_AIRFLOW}
                    + {9'h000, st_aux_q[5:2]} * 13'h0010;
    assign air_trim = air_base * 13'h0006 / 13'h0005;

    // ========================================================
    // main sequencer
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q    <= ST_START;
            tmr_q      <= 16'h0;
            hold_q     <= 16'h0;
            btn_q      <= 1'b0;
            show_id_q  <= 1'b0;
            blink_q    <= 1'b0;
            st_model_q <= 6'h00;
            st_aux_q   <= 6'h00;
            st_trim_q  <= 2'h0;
            fault_q    <= `HSC_FAULT_NONE;
        end else begin
            btn_q <= button_in;
            // hold length, saturates past the window
            if (!button_in)
                hold_q <= 16'h0;
            else if (tick && hold_q <= HOLD_MAX_T)
                hold_q <= hold_q + 16'h1;
            // short press toggles model id view, only in standby so
            // a short press never hides a pending fault
            if (btn_rel && hold_q < HOLD_MIN_T && state_q == ST_STANDBY)
                show_id_q <= ~show_id_q;
            case (state_q)
            ST_START: begin
                if (tick)
                    tmr_q <= tmr_q + 16'h1;
                if (tmr_q >= STARTUP_T) begin
                    tmr_q      <= 16'h0;
                    // power-up adopts switches as the stored set
                    st_aux_q   <= auxheat_switch_bank_in;
                    st_trim_q  <= airflow_switch_bank_in;
                    st_model_q <= model_switch_bank_in;
                    state_q    <= ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (tick) begin
                    if (tmr_q >= BLINK_T - 16'h1) begin
                        tmr_q   <= 16'h0;
                        blink_q <= ~blink_q;
                    end else begin
                        tmr_q <= tmr_q + 16'h1;
                    end
                end
                // trim raises no fault; take it when idle
                if (!call_any)
                    st_trim_q <= airflow_switch_bank_in;
                // a change seen during a call is discarded
                if (!call_any && cur_fault != `HSC_FAULT_NONE) begin
                    fault_q <= cur_fault;
                    state_q <= ST_FAULT;
                end
            end
            default: begin
                // fault shown until an accepted hold
                if (hold_ok && !call_any) begin
                    if (pend_fault == `HSC_FAULT_NONE) begin
                        if (model_switch_bank_in != `HSC_MODEL_FACTORY)
                            st_model_q <= model_switch_bank_in;
                        st_aux_q <= auxheat_switch_bank_in;
                        fault_q  <= `HSC_FAULT_NONE;
                        tmr_q    <= 16'h0;
                        state_q  <= ST_START;  // reset the board
                    end else begin
                        fault_q <= pend_fault;
                    end
                end
            end
            endcase
        end
    end

    // ========================================================
    // outputs, all registered
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            heat_relay_a_out <= 1'b0;
            heat_relay_b_out <= 1'b0;
            led_green_out    <= 1'b0;
            disp_mode_out    <= `HSC_DISP_STARTUP;
            disp_code_out    <= 8'h00;
            standby_out      <= 1'b0;
            kit_sel_out      <= 4'h0;
            heat_airflow_out <= 10'h000;
        end else begin
            standby_out   <= (state_q == ST_STANDBY);
            led_green_out <= (state_q == ST_STANDBY) & blink_q;
            kit_sel_out   <= st_aux_q[5:2];
            // base airflow scales with kit; trim 01 adds a fifth
            if (st_trim_q == `HSC_TRIM_PLUS20)
                heat_airflow_out <= air_trim[9:0];
            else
                heat_airflow_out <= air_base[9:0];
            // display selection
            if (show_id_q && state_q == ST_STANDBY) begin
                disp_mode_out <= `HSC_DISP_MODEL;
                disp_code_out <= FACTORY_ID ^ {2'h0, st_model_q};
            end else if (state_q == ST_START) begin
                disp_mode_out <= `HSC_DISP_STARTUP;
                disp_code_out <= 8'h00;
            end else if (state_q == ST_FAULT) begin
                disp_mode_out <= `HSC_DISP_FAULT;
                disp_code_out <= fault_q;
            end else begin
                disp_mode_out <= `HSC_DISP_BLANK;
                disp_code_out <= 8'h00;
            end
            // relays only in standby; heat pump defrost uses first call
            if (state_q != ST_STANDBY) begin
                heat_relay_a_out <= 1'b0;
                heat_relay_b_out <= 1'b0;
            end else begin
                case (st_aux_q[1:0])
                `HSC_STAGE_B_ONLY: begin
                    heat_relay_a_out <= 1'b0;
                    heat_relay_b_out <= first_heat_call_in
                                      | second_heat_call_in;
                end
                `HSC_STAGE_BOTH: begin
                    heat_relay_a_out <= first_heat_call_in;
                    heat_relay_b_out <= first_heat_call_in
                                      | second_heat_call_in;
                end
                default: begin
                    heat_relay_a_out <= first_heat_call_in;
                    heat_relay_b_out <= second_heat_call_in;
                end
                endcase
            end
        end
    end
endmodule // hsc_heat_stage_ctrl
`default_nettype wire

// ==== tb/hsc_chk_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.vh"
// ==========
// port checker
module hsc_chk_asserts #(
    parameter int TICK_DIV   = 2,
    parameter int STARTUP_T  = 4,
    parameter int BLINK_T    = 2,
    parameter int HOLD_MIN_T = 6,
    parameter int HOLD_MAX_T = 9
) (
    input wire logic       clock_in,            // clock
    input wire logic       rst_n_in,            // reset, low
    input wire logic       first_heat_call_in,  // call 1
    input wire logic       second_heat_call_in, // call 2
    input wire logic       other_call_in,       // other call
    input wire logic       button_in,           // button
    input wire logic       heat_relay_a_out,    // relay a
    input wire logic       heat_relay_b_out,    // relay b
    input wire logic       led_green_out,       // led
    input wire logic [1:0] disp_mode_out,       // display mode
    input wire logic [7:0] disp_code_out,       // display code
    input wire logic       standby_out          // standby
);
    // margins of one tick absorb the free-running divider phase
    localparam int ST_MIN = (STARTUP_T - 1) * TICK_DIV;
    localparam int ST_MAX = STARTUP_T * TICK_DIV + 4;
    localparam int BL_MIN = (BLINK_T - 1) * TICK_DIV + 1;
    localparam int HD_LO  = (HOLD_MIN_T - 1) * TICK_DIV;
    localparam int HD_HI  = (HOLD_MAX_T + 1) * TICK_DIV + 2;
    logic [7:0] st_q, led_cnt_q, hold_q;
    logic       led_q;
    function automatic logic [7:0] up(input logic [7:0] v);
        up = (v == 8'hFF) ? v : v + 8'h01;
    endfunction
    // run lengths, saturating so long idle spans never wrap
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q      <= 8'h00;
            led_cnt_q <= 8'hFF;
            hold_q    <= 8'h00;
            led_q     <= 1'b0;
        end else begin
            st_q      <= (disp_mode_out == `HSC_DISP_STARTUP) ? up(st_q) : 8'h00;
            led_q     <= led_green_out;
            led_cnt_q <= (led_green_out != led_q) ? 8'h01 : up(led_cnt_q);
            hold_q    <= button_in ? up(hold_q) : 8'h00;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_quiet;
        (!button_in) [*4] ##0 (disp_mode_out == `HSC_DISP_FAULT);
    endsequence
    sequence s_bad_rel;
        $fell(button_in) && (hold_q < HD_LO || hold_q > HD_HI)
            && (disp_mode_out == `HSC_DISP_FAULT);
    endsequence
    AST_RELAY_IDLE: assert property (standby_out && !first_heat_call_in
        && !second_heat_call_in |=> !heat_relay_a_out && !heat_relay_b_out)
        else $error("heat relay on without a call");
    AST_RELAY_SECOND: assert property (standby_out && second_heat_call_in
        |=> heat_relay_b_out) else $error("second call left relay b off");
    AST_RELAY_FIRST: assert property (standby_out && first_heat_call_in
        |=> heat_relay_a_out || heat_relay_b_out)
        else $error("first call drove no relay");
    AST_STARTUP_MIN: assert property ($rose(standby_out) |-> st_q >= ST_MIN)
        else $error("standby entered too early");
    AST_STARTUP_MAX: assert property (st_q <= ST_MAX)
        else $error("startup delay overran");
    AST_BLINK: assert property (standby_out && $past(standby_out)
        && $changed(led_green_out) |-> led_cnt_q >= BL_MIN)
        else $error("led blink half period too short");
    AST_CALL_NO_FAULT: assert property (standby_out && (first_heat_call_in
        || second_heat_call_in || other_call_in)
        |=> disp_mode_out != `HSC_DISP_FAULT) else $error("fault under a call");
    AST_FAULT_HOLD: assert property (s_quiet |=>
        disp_mode_out == `HSC_DISP_FAULT) else $error("fault cleared unasked");
    AST_HOLD_RANGE: assert property (s_bad_rel |=>
        (disp_mode_out == `HSC_DISP_FAULT) [*4]) else $error("bad hold accepted");
    AST_FAULT_CODE: assert property (disp_mode_out == `HSC_DISP_FAULT
        |-> disp_code_out inside {8'h01, 8'h02, 8'h03, 8'h04})
        else $error("fault code out of range");
endmodule // hsc_chk_asserts
bind hsc_heat_stage_ctrl hsc_chk_asserts #(.TICK_DIV(TICK_DIV),
    .STARTUP_T(STARTUP_T), .BLINK_T(BLINK_T), .HOLD_MIN_T(HOLD_MIN_T),
    .HOLD_MAX_T(HOLD_MAX_T)) i_hsc_chk_asserts (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .first_heat_call_in(first_heat_call_in),
    .second_heat_call_in(second_heat_call_in), .other_call_in(other_call_in),
    .button_in(button_in), .heat_relay_a_out(heat_relay_a_out),
    .heat_relay_b_out(heat_relay_b_out), .led_green_out(led_green_out),
    .disp_mode_out(disp_mode_out), .disp_code_out(disp_code_out),
    .standby_out(standby_out));
`default_nettype wire

// ==== tb/hsc_stat_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// thermostat and heat pump calls
module hsc_stat_model (
    input  wire logic clock_in,              // board clock
    input  wire logic defrost_in,            // heat pump defrosting
    input  wire logic stage2_in,             // stat wants more heat
    input  wire logic other_in,              // cooling or fan call
    output var  logic first_call_out = 1'b0, // first heat call
    output var  logic second_call_out = 1'b0, // second heat call
    output var  logic other_call_out = 1'b0  // other call
);
    // calls move only after a falling edge, clear of the sampling edge
    always_ff @(negedge clock_in) begin
        first_call_out  <= defrost_in;
        second_call_out <= stage2_in;
        other_call_out  <= other_in;
    end
endmodule // hsc_stat_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.vh"
module tb_top;
    logic clock_in = 1'b0, rst_n_in = 1'b0, button = 1'b0, blower = 1'b1;
    logic [5:0] model_sw = 6'h00, aux_sw = 6'h14;
    logic [1:0] trim_sw = 2'h0, mode;
    logic defrost = 1'b0, stage2 = 1'b0, other = 1'b0, led_prev;
    logic c1, c2, co, rly_a, rly_b, led, standby;
    logic [7:0] code;
    logic [3:0] kit;
    logic [9:0] airflow;
    int n_mismatch = 0, n_tests = 0, i, k;
    always #2.5 clock_in = ~clock_in;
    hsc_stat_model i_hsc_stat_model (.clock_in(clock_in), .defrost_in(defrost),
        .stage2_in(stage2), .other_in(other), .first_call_out(c1),
        .second_call_out(c2), .other_call_out(co));
    hsc_heat_stage_ctrl #(.TICK_DIV(2), .STARTUP_T(16'd4), .BLINK_T(16'd2),
        .HOLD_MIN_T(16'd6), .HOLD_MAX_T(16'd9)) i_hsc_heat_stage_ctrl (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .model_switch_bank_in(model_sw),
        .auxheat_switch_bank_in(aux_sw), .airflow_switch_bank_in(trim_sw),
        .first_heat_call_in(c1), .second_heat_call_in(c2), .other_call_in(co),
        .button_in(button), .blower_match_in(blower), .heat_relay_a_out(rly_a),
        .heat_relay_b_out(rly_b), .led_green_out(led), .disp_mode_out(mode),
        .disp_code_out(code), .standby_out(standby), .kit_sel_out(kit),
        .heat_airflow_out(airflow));
    // ==========
    // helpers
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    // held for n clocks; settle time lets the outcome register
    task automatic press(input int n);
        button = 1'b1;
        step(n);
        button = 1'b0;
        step(6);
    endtask
    task automatic wait_sb;
        for (i = 0; i < 60 && standby !== 1'b1; i++) step(1);
        chk({9'h000, standby}, 10'h001);
    endtask
    task automatic fault(input logic [7:0] c);
        chk({mode, code}, {`HSC_DISP_FAULT, c});
    endtask
    task automatic rly(input logic d, input logic s, input logic [1:0] exp);
        defrost <= d;
        stage2 <= s;
        step(4);
        chk({8'h00, rly_a, rly_b}, {8'h00, exp});
        defrost <= 1'b0;
        stage2 <= 1'b0;
        step(4);
    endtask
    // ==========
    // watchdog: the run needs about four hundred clocks
    initial begin
        #20000;
        n_mismatch++;
        wrap_up();
    end
    // ==========
    // scenarios
    initial begin
        step(3);
        chk({1'b0, code, standby}, 10'h000);
        chk({8'h00, mode}, {8'h00, `HSC_DISP_STARTUP});
        rst_n_in = 1'b1;
        wait_sb();
        chk({6'h00, kit}, 10'h005);
        chk(airflow, 10'h090);
        trim_sw = `HSC_TRIM_PLUS20;
        step(4);
        chk(airflow, 10'h0AC);
        trim_sw = 2'h0;
        led_prev = led;
        step(4);
        chk({9'h000, led}, {9'h000, ~led_prev});
        rly(1'b1, 1'b0, 2'b10);
        rly(1'b0, 1'b1, 2'b01);
        rly(1'b1, 1'b1, 2'b11);
        // remap the first call through stage settings 01, 10 and 11
        for (k = 1; k < 4; k++) begin
            aux_sw = {4'h5, k[1:0]};
            step(6);
            press(15);
            wait_sb();
            rly(1'b1, 1'b0, {k[1:0] != 2'h2, k[1:0] != 2'h1});
        end
        aux_sw = 6'h0B;
        step(6);
        fault(`HSC_FAULT_KIT);
        press(6);
        fault(`HSC_FAULT_KIT);
        press(24);
        fault(`HSC_FAULT_KIT);
        press(15);
        fault(`HSC_FAULT_STAGE);
        aux_sw = 6'h08;
        step(2);
        press(15);
        wait_sb();
        chk({6'h00, kit}, 10'h002);
        // a move under an active call must be dropped
        other <= 1'b1;
        step(3);
        aux_sw = 6'h1C;
        step(6);
        chk({8'h00, mode}, {8'h00, `HSC_DISP_BLANK});
        aux_sw = 6'h08;
        step(3);
        other <= 1'b0;
        step(6);
        chk({6'h00, kit}, 10'h002);
        model_sw = 6'h15;
        step(6);
        fault(`HSC_FAULT_MODEL);
        model_sw = 6'h00;
        step(6);
        fault(`HSC_FAULT_MODEL);
        press(15);
        wait_sb();
        press(2);
        chk({mode, code}, {`HSC_DISP_MODEL, 8'h5A});
        press(2);
        blower = 1'b0;
        step(6);
        fault(`HSC_FAULT_BLOWER);
        blower = 1'b1;
        press(15);
        wait_sb();
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
